// >>> gml_annunciator.sv
// scan hold control, led annunciation, fault codes and wishbone registers
`timescale 1ns/1ps
module gml_annunciator #(
   parameter logic [39:0] HOLD_IDLE_CYC = gml_pkg::HOLD_IDLE_CYC,
   parameter logic [31:0] BLINK_HALF_CYC = gml_pkg::BLINK_HALF_CYC,
   parameter logic [31:0] SCAN_DWELL_CYC = gml_pkg::SCAN_DWELL_CYC,
   parameter int NCH = 4
) (
   input wire logic core_clk,
   input wire logic srst,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq,
   // front panel buttons and status pins, asynchronous
   input wire logic btn_hold,
   input wire logic btn_esc,
   input wire logic [3:0] relay_alarm, // alarm condition present per relay
   input wire logic monitor_fault, // monitor internal fault
   // adc samples, same clock domain
   input wire logic [NCH-1:0] sample_valid,
   input wire logic [NCH-1:0][15:0] loop_ua,
   // indicators
   output logic [3:0] alarm_led,
   output logic fault_led,
   output logic status_led_red,
   output logic status_led_blue,
   output logic [1:0] sel_chan, // channel shown; all channels are converted and monitored
   output logic scan_held
);
   // pin synchroniser: {monitor_fault, relay_alarm, esc, hold}
   logic [6:0] pin_s1_q, pin_s2_q, pin_p_q;
   logic [6:0] pin_raw;
   logic hold_press, esc_press, any_press;
   logic [3:0] live_alarm;
   logic mfault;

   // scan state
   gml_pkg::gml_scan_t state_q, state_d;
   logic [1:0] chan_q, chan_d;
   logic [31:0] dwell_q, dwell_d;
   logic [39:0] idle_q, idle_d;
   logic timeout_ev;

   // blink and annunciation
   logic [31:0] blink_cnt_q, blink_cnt_d;
   logic blink_q, blink_d;
   logic [3:0] seen_q, seen_d; // alarm happened since reset
   logic fseen_q, fseen_d; // sensor fault happened since reset
   logic fnow_q, fnow_d; // previous sensor fault level, for the rise event
   logic [3:0] aled_d;
   logic fled_d;

   // registers
   logic [5:0] sts_q, sts_d, mask_q, mask_d, sts_set;
   logic [NCH-1:0][15:0] scale_q, scale_d;
   logic ack_d;
   logic [31:0] dat_d;
   logic irq_d;
   logic wb_req;
   logic [31:0] wmask;

   // conversion results
   logic [NCH-1:0][15:0] value;
   logic [NCH-1:0][7:0] code;
   logic fault_any;

   assign pin_raw = {monitor_fault, relay_alarm, btn_esc, btn_hold};

   // two flops before use, a third keeps history for press edges
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pin_s1_q <= 7'h00;
         pin_s2_q <= 7'h00;
         pin_p_q <= 7'h00;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_p_q <= pin_s2_q;
      end
   end

   // no debounce: buttons are assumed clean by the panel hardware
   assign hold_press = pin_s2_q[0] & ~pin_p_q[0];
   assign esc_press = pin_s2_q[1] & ~pin_p_q[1];
   assign any_press = hold_press | esc_press;
   assign live_alarm = pin_s2_q[5:2];
   assign mfault = pin_s2_q[6];

   // one converter per channel
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_conv
         gml_loop_conv u_conv (
            .core_clk(core_clk),
            .srst(srst),
            .sample_valid(sample_valid[gi]),
            .loop_ua(loop_ua[gi]),
            .scale(scale_q[gi]),
            .value_q(value[gi]),
            .code_q(code[gi])
         );
      end
   endgenerate

   assign fault_any = |code;

   // scan stepping and hold with idle timeout
   always_comb begin
      state_d = state_q;
      chan_d = chan_q;
      dwell_d = dwell_q;
      idle_d = idle_q;
      timeout_ev = 1'b0;
      case (state_q)
         gml_pkg::GML_SCAN: begin
            if (hold_press) begin
               state_d = gml_pkg::GML_HOLD;
               idle_d = 40'h0;
            end else if (dwell_q >= SCAN_DWELL_CYC - 32'h1) begin
               dwell_d = 32'h0;
               chan_d = chan_q + 2'h1;
            end else begin
               dwell_d = dwell_q + 32'h1;
            end
         end
         gml_pkg::GML_HOLD: begin
            // leaving hold keeps the held channel and restarts its dwell
            if (esc_press) begin
               state_d = gml_pkg::GML_SCAN;
               dwell_d = 32'h0;
            end else if (hold_press) begin
               idle_d = 40'h0;
            end else if (idle_q >= HOLD_IDLE_CYC - 40'h1) begin
               state_d = gml_pkg::GML_SCAN;
               dwell_d = 32'h0;
               timeout_ev = 1'b1;
            end else begin
               idle_d = idle_q + 40'h1;
            end
         end
         default: begin
            state_d = gml_pkg::GML_SCAN;
         end
      endcase
   end

   // scan registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q <= gml_pkg::GML_SCAN;
         chan_q <= 2'h0;
         dwell_q <= 32'h0;
         idle_q <= 40'h0;
      end else begin
         state_q <= state_d;
         chan_q <= chan_d;
         dwell_q <= dwell_d;
         idle_q <= idle_d;
      end
   end

   // led annunciation from live conditions and what was seen since reset
   always_comb begin
      blink_cnt_d = blink_cnt_q + 32'h1;
      blink_d = blink_q;
      if (blink_cnt_q >= BLINK_HALF_CYC - 32'h1) begin
         blink_cnt_d = 32'h0;
         blink_d = ~blink_q;
      end
      seen_d = seen_q | live_alarm;
      fseen_d = fseen_q | fault_any;
      fnow_d = fault_any;
      for (int i = 0; i < 4; i++) begin
         if (live_alarm[i]) begin
            aled_d[i] = 1'b1;
         end else if (seen_q[i]) begin
            aled_d[i] = blink_q;
         end else begin
            aled_d[i] = 1'b0;
         end
      end
      // a past fault that has cleared blinks so it is not silently lost
      if (fault_any) begin
         fled_d = 1'b1;
      end else if (fseen_q) begin
         fled_d = blink_q;
      end else begin
         fled_d = 1'b0;
      end
   end

   // annunciation registers and leds
   always_ff @(posedge core_clk) begin
      if (srst) begin
         blink_cnt_q <= 32'h0;
         blink_q <= 1'b0;
         seen_q <= 4'h0;
         fseen_q <= 1'b0;
         fnow_q <= 1'b0;
         alarm_led <= 4'h0;
         fault_led <= 1'b0;
         status_led_red <= 1'b0;
         status_led_blue <= 1'b0;
         sel_chan <= 2'h0;
         scan_held <= 1'b0;
      end else begin
         blink_cnt_q <= blink_cnt_d;
         blink_q <= blink_d;
         seen_q <= seen_d;
         fseen_q <= fseen_d;
         fnow_q <= fnow_d;
         alarm_led <= aled_d;
         fault_led <= fled_d;
         status_led_red <= mfault;
         status_led_blue <= ~mfault;
         sel_chan <= chan_d;
         scan_held <= (state_d == gml_pkg::GML_HOLD);
      end
   end

   // bus request, write byte mask, interrupt sources
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   end
   assign sts_set = {timeout_ev, fault_any & ~fnow_q, live_alarm & ~seen_q};

   // register file: write and read on the edge that raises ack
   always_comb begin
      logic [31:0] merged;
      merged = 32'h0;
      mask_d = mask_q;
      scale_d = scale_q;
      ack_d = wb_req;
      dat_d = 32'h0;
      // set wins over a simultaneous write-one clear
      sts_d = sts_q | sts_set;
      if (wb_req) begin
         case (wb_adr_i)
            gml_pkg::OFS_STATUS: begin
               dat_d[gml_pkg::STS_CHAN_LSB +: 2] = sel_chan;
               dat_d[gml_pkg::STS_HELD_BIT] = scan_held;
               dat_d[gml_pkg::STS_ALED_LSB +: 4] = alarm_led;
               dat_d[gml_pkg::STS_FLED_BIT] = fault_led;
               dat_d[gml_pkg::STS_MFLT_BIT] = status_led_red;
               dat_d[gml_pkg::STS_LIVE_LSB +: 4] = live_alarm;
            end
            gml_pkg::OFS_IRQ_STS: begin
               dat_d[5:0] = sts_q;
               if (wb_we_i) begin
                  sts_d = (sts_q & ~(wb_dat_i[5:0] & wmask[5:0])) | sts_set;
               end
            end
            gml_pkg::OFS_IRQ_MASK: begin
               dat_d[5:0] = mask_q;
               if (wb_we_i) begin
                  mask_d = (mask_q & ~wmask[5:0]) | (wb_dat_i[5:0] & wmask[5:0]);
               end
            end
            default: begin
               // scale and value words by index; other addresses read zero
               for (int c = 0; c < NCH; c++) begin
                  if (wb_adr_i == gml_pkg::OFS_SCALE0 + 8'(4 * c)) begin
                     dat_d[15:0] = scale_q[c];
                     if (wb_we_i) begin
                        merged = ({16'h0, scale_q[c]} & ~wmask) | (wb_dat_i & wmask);
                        if (merged[15:0] < gml_pkg::SCALE_MIN) begin
                           scale_d[c] = gml_pkg::SCALE_MIN;
                        end else if (merged[15:0] > gml_pkg::SCALE_MAX) begin
                           scale_d[c] = gml_pkg::SCALE_MAX;
                        end else begin
                           scale_d[c] = merged[15:0];
                        end
                     end
                  end
                  if (wb_adr_i == gml_pkg::OFS_VALUE0 + 8'(4 * c)) begin
                     dat_d[15:0] = value[c];
                     dat_d[gml_pkg::VAL_CODE_LSB +: 8] = code[c];
                  end
               end
            end
         endcase
      end
      irq_d = |(sts_d & mask_d);
   end

   // register file flops
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sts_q <= 6'h00;
         mask_q <= gml_pkg::IRQ_MASK_RST;
         for (int c = 0; c < NCH; c++) begin
            scale_q[c] <= gml_pkg::SCALE_RST;
         end
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         irq <= 1'b0;
      end else begin
         sts_q <= sts_d;
         mask_q <= mask_d;
         scale_q <= scale_d;
         wb_ack_o <= ack_d;
         wb_dat_o <= dat_d;
         irq <= irq_d;
      end
   end
endmodule : gml_annunciator

// >>> gml_annunciator_sva.sv
// port checker for the gas monitor annunciator, bound onto the top module
`timescale 1ns/1ps
module gml_annunciator_sva #(
   parameter logic [39:0] HOLD_IDLE_CYC = gml_pkg::HOLD_IDLE_CYC,
   parameter logic [31:0] SCAN_DWELL_CYC = gml_pkg::SCAN_DWELL_CYC
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic btn_hold,
   input wire logic btn_esc,
   input wire logic [3:0] relay_alarm,
   input wire logic monitor_fault,
   input wire logic [3:0] alarm_led,
   input wire logic status_led_red,
   input wire logic status_led_blue,
   input wire logic [1:0] sel_chan,
   input wire logic scan_held
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   logic [31:0] dwell_q, dwell_d; // cycles since the shown channel last moved or was last held
   logic [39:0] idle_q, idle_d; // held cycles since any button pin was high
   logic seen_q, seen_d; // relay 1 pin has been high since reset
   logic [1:0] chan_q; // channel of the previous cycle
   // next values; pin-level idle count is later than the block's own, so it never overcounts
   always_comb begin
      dwell_d = (scan_held || sel_chan != chan_q) ? 32'h0 : dwell_q + 32'h1;
      idle_d = (!scan_held || btn_hold || btn_esc) ? 40'h0 : idle_q + 40'h1;
      seen_d = seen_q | relay_alarm[1];
   end
   // helper registers, cleared with the block
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dwell_q <= 32'h0;
         idle_q <= 40'h0;
         seen_q <= 1'b0;
         chan_q <= 2'h0;
      end else begin
         dwell_q <= dwell_d;
         idle_q <= idle_d;
         seen_q <= seen_d;
         chan_q <= sel_chan;
      end
   end
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stood longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   scan_step_a: assert property (dwell_q <= SCAN_DWELL_CYC)
      else $error("channel stopped stepping");
   hold_freeze_a: assert property (scan_held [*2] |-> $stable(sel_chan))
      else $error("channel moved while held");
   hold_limit_a: assert property (idle_q <= HOLD_IDLE_CYC + 40'h6)
      else $error("hold outlived the idle time");
   alarm_solid_a: assert property (relay_alarm[1] [*6] |-> alarm_led[1])
      else $error("alarm led not solid");
   alarm_dark_a: assert property (!seen_q |-> !alarm_led[1])
      else $error("alarm led lit without alarm");
   status_red_a: assert property (monitor_fault [*6] |-> status_led_red && !status_led_blue)
      else $error("status led not red");
   status_blue_a: assert property (!monitor_fault [*6] |-> status_led_blue && !status_led_red)
      else $error("status led not blue");
endmodule : gml_annunciator_sva

bind gml_annunciator gml_annunciator_sva #(
   .HOLD_IDLE_CYC(HOLD_IDLE_CYC),
   .SCAN_DWELL_CYC(SCAN_DWELL_CYC)
) chk (
   .core_clk(core_clk),
   .srst(srst),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o),
   .btn_hold(btn_hold),
   .btn_esc(btn_esc),
   .relay_alarm(relay_alarm),
   .monitor_fault(monitor_fault),
   .alarm_led(alarm_led),
   .status_led_red(status_led_red),
   .status_led_blue(status_led_blue),
   .sel_chan(sel_chan),
   .scan_held(scan_held)
);

// >>> gml_annunciator_test.sv
// self-checking bench for the gas monitor annunciator
`timescale 1ns/1ps
module gml_annunciator_test;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic btn_hold = 1'b0;
   logic btn_esc = 1'b0;
   logic [3:0] relay_alarm = 4'h0;
   logic monitor_fault = 1'b0;
   logic [3:0][15:0] set_ua = {4{16'h0fa0}}; // every sensor at zero reading
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, irq, fault_led, status_led_red, status_led_blue, scan_held;
   logic [3:0] sample_valid, alarm_led;
   logic [3:0][15:0] loop_ua;
   logic [1:0] sel_chan, chan;
   int bad_count = 0;
   int n_compared = 0;
   int on;
   // conversion table: scale written, loop current, scale read back, value word
   logic [15:0] t_sc[7] = '{16'h03e8, 16'h0000, 16'hffff, 16'hfde8, 16'hfde8, 16'hfde8, 16'h0001};
   logic [15:0] t_ua[7] = '{16'h2ee0, 16'h4e20, 16'h4e20, 16'h0fa0, 16'h01f4, 16'h0bb8, 16'h0000};
   logic [15:0] t_rb[7] = '{16'h03e8, 16'h0001, 16'hfde8, 16'hfde8, 16'hfde8, 16'hfde8, 16'h0001};
   logic [31:0] t_v[7] = '{32'h1f4, 32'h1, 32'hfde8, 32'h0, 32'ha0000, 32'hd0000, 32'ha0000};

   gml_annunciator #(.HOLD_IDLE_CYC(40'h0c8), .BLINK_HALF_CYC(32'h8), .SCAN_DWELL_CYC(32'h10)) dut (
      .core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .btn_hold(btn_hold),
      .btn_esc(btn_esc), .relay_alarm(relay_alarm), .monitor_fault(monitor_fault),
      .sample_valid(sample_valid), .loop_ua(loop_ua), .alarm_led(alarm_led),
      .fault_led(fault_led), .status_led_red(status_led_red),
      .status_led_blue(status_led_blue), .sel_chan(sel_chan), .scan_held(scan_held));
   gml_sensor_model #(.NCH(4)) sensors (.core_clk(core_clk), .srst(srst), .set_ua(set_ua),
      .sample_valid(sample_valid), .loop_ua(loop_ua));

   // free-running 125 mhz clock
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test;
      $display("compared %0d, wrong %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   // one classic cycle; the master waits for ack, bounded, and takes data at that edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (wb_ack_o !== 1'b1) begin
         bad_count++;
         end_of_test();
      end
   endtask : wb
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   // press held four cycles, longer than the two-flop synchroniser
   task automatic press(input logic esc);
      @(posedge core_clk);
      {btn_esc, btn_hold} <= esc ? 2'b10 : 2'b01;
      tick(4);
      {btn_esc, btn_hold} <= 2'b00;
   endtask : press
   // wait for the shown channel to move, bounded
   task automatic wait_step;
      int n;
      n = 0;
      chan = sel_chan;
      while (sel_chan === chan && n < 40) begin
         tick(1);
         n++;
      end
      // a channel that never moves is a hang: count it and close the run
      if (sel_chan === chan) begin
         bad_count++;
         end_of_test();
      end
   endtask : wait_step

   // main sequence
   initial begin
      tick(8);
      srst <= 1'b0;
      wb(0, gml_pkg::OFS_SCALE0, 0);
      check(rd, 32'h64);
      wb(1, 8'h40, 32'hffffffff);
      wb(0, 8'h40, 0);
      check(rd, 32'h0);
      check(fault_led, 1'b0);
      for (int i = 0; i < 7; i++) begin
         wb(1, 8'(gml_pkg::OFS_SCALE0 + 8'(4 * (i % 4))), {16'h0, t_sc[i]});
         set_ua[i % 4] <= t_ua[i];
         tick(12);
         wb(0, 8'(gml_pkg::OFS_SCALE0 + 8'(4 * (i % 4))), 0);
         check(rd, {16'h0, t_rb[i]});
         wb(0, 8'(gml_pkg::OFS_VALUE0 + 8'(4 * (i % 4))), 0);
         check(rd, t_v[i]);
      end
      set_ua <= {4{16'h0fa0}};
      tick(12);
      wb(1, gml_pkg::OFS_IRQ_STS, 32'h3f);
      set_ua[2] <= 16'h07d0;
      tick(12);
      check(fault_led, 1'b1);
      check(irq, 1'b0);
      wb(0, gml_pkg::OFS_IRQ_STS, 0);
      check(rd, 32'h10);
      wb(1, gml_pkg::OFS_IRQ_MASK, 32'h10);
      tick(2);
      check(irq, 1'b1);
      wb(1, gml_pkg::OFS_IRQ_STS, 32'h10);
      tick(2);
      check(irq, 1'b0);
      set_ua[2] <= 16'h0fa0;
      check(alarm_led, 4'h0);
      relay_alarm <= 4'h2;
      tick(6);
      check(alarm_led, 4'h2);
      wb(0, gml_pkg::OFS_STATUS, 0);
      check(rd & 32'h1e78, 32'h410);
      relay_alarm <= 4'h0;
      tick(6);
      on = 0;
      repeat (20) begin
         tick(1);
         on += int'(alarm_led[1] === 1'b1);
         check({alarm_led[3:2], alarm_led[0]}, 3'h0);
      end
      check(on > 0 && on < 20, 1'b1);
      monitor_fault <= 1'b1;
      tick(6);
      check({status_led_red, status_led_blue}, 2'b10);
      monitor_fault <= 1'b0;
      tick(6);
      check({status_led_red, status_led_blue}, 2'b01);
      wait_step();
      check(sel_chan !== chan, 1'b1);
      press(0);
      tick(4);
      check(scan_held, 1'b1);
      chan = sel_chan;
      tick(40);
      check(sel_chan, chan);
      press(1);
      tick(4);
      check(scan_held, 1'b0);
      wait_step();
      check(sel_chan, 2'(chan + 2'h1));
      press(0);
      tick(150);
      press(0);
      tick(150);
      check(scan_held, 1'b1);
      on = 0;
      while (scan_held === 1'b1 && on < 80) begin
         tick(1);
         on++;
      end
      // a hold that never times out is a hang: count it and close the run
      if (scan_held === 1'b1) begin
         bad_count++;
         end_of_test();
      end
      check(scan_held, 1'b0);
      wb(0, gml_pkg::OFS_IRQ_STS, 0);
      check(rd, 32'h22);
      end_of_test();
   end
endmodule : gml_annunciator_test

// >>> gml_loop_conv.sv
// one channel of loop current to gas value conversion with fault coding
`timescale 1ns/1ps
module gml_loop_conv (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic sample_valid, // new adc sample this cycle
   input wire logic [15:0] loop_ua, // loop current in microamps
   input wire logic [15:0] scale, // full scale, already clamped
   output logic [15:0] value_q, // gas value
   output logic [7:0] code_q // fault code, zero when healthy
);
   logic [15:0] value_d;
   logic [7:0] code_d;
   logic [15:0] span; // current above 4 mA, clamped to the span
   logic [31:0] prod;

   // classify the sample, then scale the span linearly
   always_comb begin
      value_d = value_q;
      code_d = code_q;
      span = 16'h0000;
      prod = 32'h0000_0000;
      if (sample_valid) begin
         if (loop_ua < gml_pkg::LOOP_OPEN_UA) begin
            // dead loop or sensor, never read as a zero reading
            code_d = gml_pkg::SENSOR_NO_COMM_FAULT_CODE;
            value_d = 16'h0000;
         end else if (loop_ua < gml_pkg::LOOP_FAULT_UA) begin
            // sensor drives a sub-4 mA fault level; cause not visible here
            code_d = gml_pkg::SENSOR_LOOP_FAULT_CODE;
            value_d = 16'h0000;
         end else begin
            code_d = gml_pkg::CODE_NONE;
            // small undershoot around 4 mA reads as zero, overrange as full scale
            if (loop_ua <= gml_pkg::LOOP_ZERO_UA) begin
               span = 16'h0000;
            end else if (loop_ua - gml_pkg::LOOP_ZERO_UA > gml_pkg::LOOP_SPAN_UA) begin
               span = gml_pkg::LOOP_SPAN_UA;
            end else begin
               span = loop_ua - gml_pkg::LOOP_ZERO_UA;
            end
            // divide by a constant; truncates toward zero
            prod = 32'(span) * 32'(scale);
            value_d = 16'(prod / 32'(gml_pkg::LOOP_SPAN_UA));
         end
      end
   end

   // register result
   always_ff @(posedge core_clk) begin
      if (srst) begin
         value_q <= 16'h0000;
         code_q <= gml_pkg::CODE_NONE;
      end else begin
         value_q <= value_d;
         code_q <= code_d;
      end
   end
endmodule : gml_loop_conv

// >>> gml_pkg.sv
// constants shared by the gas monitor status and annunciator block
package gml_pkg;
   // clock rate and documented times
   localparam longint unsigned CLK_HZ = 125_000_000;
   localparam longint unsigned HOLD_IDLE_S = 300; // five minutes
   localparam longint unsigned BLINK_HALF_MS = 500; // one hertz blink
   localparam longint unsigned SCAN_DWELL_MS = 2000; // time shown per channel
   localparam logic [39:0] HOLD_IDLE_CYC = 40'(CLK_HZ * HOLD_IDLE_S);
   localparam logic [31:0] BLINK_HALF_CYC = 32'(CLK_HZ * BLINK_HALF_MS / 1000);
   localparam logic [31:0] SCAN_DWELL_CYC = 32'(CLK_HZ * SCAN_DWELL_MS / 1000);

   // loop current thresholds in microamps
   localparam logic [15:0] LOOP_ZERO_UA = 16'd4000; // zero reading
   localparam logic [15:0] LOOP_SPAN_UA = 16'd16000; // 4..20 mA span
   localparam logic [15:0] LOOP_OPEN_UA = 16'd1000; // below this the loop is dead
   localparam logic [15:0] LOOP_FAULT_UA = 16'd3800; // below this the sensor signals fault

   // fault codes
   localparam logic [7:0] SENSOR_NO_COMM_FAULT_CODE = 8'h0a; // 10
   localparam logic [7:0] SENSOR_LOOP_FAULT_CODE = 8'h0d; // 13
   localparam logic [7:0] CODE_NONE = 8'h00;

   // full scale limits and reset value
   localparam logic [15:0] SCALE_MIN = 16'h0001;
   localparam logic [15:0] SCALE_MAX = 16'hfde8; // 65000
   localparam logic [15:0] SCALE_RST = 16'h0064; // 100

   // register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_IRQ_STS = 8'h04;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
   localparam logic [7:0] OFS_SCALE0 = 8'h0c; // four words, one per channel
   localparam logic [7:0] OFS_VALUE0 = 8'h1c; // four words, one per channel
   localparam logic [5:0] IRQ_MASK_RST = 6'h00;

   // status register fields
   localparam int STS_CHAN_LSB = 0; // 2 bits
   localparam int STS_HELD_BIT = 2;
   localparam int STS_ALED_LSB = 3; // 4 bits
   localparam int STS_FLED_BIT = 7;
   localparam int STS_MFLT_BIT = 8;
   localparam int STS_LIVE_LSB = 9; // 4 bits
   // value register fields
   localparam int VAL_CODE_LSB = 16; // 8 bits
   // interrupt bits: 3..0 first relay alarm since reset, 4 sensor fault rise, 5 hold timeout
   localparam int IRQ_SFLT_BIT = 4;
   localparam int IRQ_TOUT_BIT = 5;

   // scan states
   typedef enum logic {
      GML_SCAN,
      GML_HOLD
   } gml_scan_t;
endpackage : gml_pkg

// >>> gml_sensor_model.sv
// behavioural model of the loop-powered gas sensor assemblies
`timescale 1ns/1ps
module gml_sensor_model #(
   parameter int NCH = 4
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [NCH-1:0][15:0] set_ua, // loop current each sensor sinks, microamps
   output logic [NCH-1:0] sample_valid,
   output logic [NCH-1:0][15:0] loop_ua
);
   logic [1:0] tick_q, tick_d; // converter pacing, one sample every four cycles
   // next pacing count
   always_comb begin
      tick_d = tick_q + 2'h1;
   end
   // pacing register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tick_q <= 2'h0;
      end else begin
         tick_q <= tick_d;
      end
   end
   // outside a strobe the bus shows inverted junk so stale reads are caught
   always_comb begin
      sample_valid = {NCH{tick_q == 2'h3}};
      loop_ua = sample_valid[0] ? set_ua : ~set_ua;
   end
endmodule : gml_sensor_model
